// ---- src/sarstk_pkg.sv ----
// Package for the address recovery stack: offsets, field layout, bus constants
package sarstk_pkg;
    localparam int SARSTK_DATA_W = 8;
    localparam int SARSTK_ADDR_W = 7;
    localparam int SARSTK_DEPTH = 4;
    localparam int SARSTK_IDX_W = 2;
    // Stack slot offsets in the second bank
    localparam logic [6:0] SARSTK_OFF_INTERRUPTED = 7'h4E;
    localparam logic [6:0] SARSTK_OFF_OLDER = 7'h4F;
    // Control register A and its bank-select bit
    localparam logic [6:0] SARSTK_OFF_CTRL_A = 7'h0A;
    localparam int SARSTK_BANK_BIT = 4;
    // Entry layout
    localparam int SARSTK_ENTRY_BANK_POS = 7;
    // Stack positions read by the two slots
    localparam logic [1:0] SARSTK_POS_INTERRUPTED = 2'h2;
    localparam logic [1:0] SARSTK_POS_OLDER = 2'h3;
    localparam logic [7:0] SARSTK_ENTRY_RESET = 8'h00;
    localparam logic [7:0] SARSTK_CTRL_A_RESET = 8'h00;
endpackage

// ---- src/sarstk_shift_mem.sv ----
// Four-entry push-down stack with registered read port
`timescale 1ns/1ns
`default_nettype none
module sarstk_shift_mem
    import sarstk_pkg::*;
#(
    parameter int WIDTH = SARSTK_DATA_W,
    parameter int DEPTH = SARSTK_DEPTH,
    parameter int IDX_W = SARSTK_IDX_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Push side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Read side
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [WIDTH-1:0] rd_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ent <= '0;
            rd_q <= '0;
        end else if (clk_en) begin
            rd_q <= ent[rd_idx];
            if (push) begin
                ent[0] <= push_data;
                for (int i = 1; i < DEPTH; i++) begin
                    ent[i] <= ent[i-1];
                end
            end
        end
    end
    assign rd_data = rd_q;
endmodule // sarstk_shift_mem
`default_nettype wire

// ---- src/sarstk_top.sv ----
// Address recovery stack on a multiplexed host bus
// Behaviour
// - The stack is readable at second-bank offsets 4Eh and 4Fh.
// - Each entry holds the bank-select bit in bit 7 and the seven address bits below it.
// - The address is captured from the bus on the falling edge of the latch strobe.
// - Every capture pushes the stack with the new address on top.
// - The stack is four deep and drops its oldest entry on a push.
// - Latching 4Eh then leaves the lost address two deep, which a read at 4Eh returns.
// - Address and data share the eight bus lines, address phase first.
`timescale 1ns/1ns
`default_nettype none
module sarstk_top
    import sarstk_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Host bus
    input wire logic addr_latch,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe_n,
    // Status
    output logic bank_select_bit
);
    typedef struct packed {
        logic ale_q;
        logic rd_q;
        logic wr_q;
        logic [6:0] addr;
        logic [7:0] ctrl_a;
        logic [7:0] dout;
        logic oe_n;
    } sarstk_state_t;

    sarstk_state_t st, next_st;
    logic push;
    logic [7:0] push_data;
    logic [1:0] rd_idx;
    logic [7:0] stk_data;
    logic hit_stack;

    sarstk_shift_mem #(
        .WIDTH(SARSTK_DATA_W),
        .DEPTH(SARSTK_DEPTH),
        .IDX_W(SARSTK_IDX_W)
    ) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .push(push),
        .push_data(push_data),
        .rd_idx(rd_idx),
        .rd_data(stk_data)
    );

    always_comb begin
        next_st = st;
        push = 1'b0;
        hit_stack = st.ctrl_a[SARSTK_BANK_BIT]
            && (st.addr == SARSTK_OFF_INTERRUPTED || st.addr == SARSTK_OFF_OLDER);
        rd_idx = (st.addr == SARSTK_OFF_OLDER) ? SARSTK_POS_OLDER : SARSTK_POS_INTERRUPTED;
        push_data = {st.ctrl_a[SARSTK_BANK_BIT], bus_in[6:0]};
        next_st.ale_q = addr_latch;
        next_st.rd_q = !rd_n && !cs_n;
        next_st.wr_q = !wr_n && !cs_n;
        // Falling edge of the latch strobe captures the address phase
        if (st.ale_q && !addr_latch) begin
            next_st.addr = bus_in[6:0];
            push = 1'b1;
        end
        // Data phase: only control register A is writable here
        if (!wr_n && !cs_n && !st.wr_q && st.addr == SARSTK_OFF_CTRL_A) begin
            next_st.ctrl_a = bus_in;
        end
        // Stack slot writes fall through untouched
        // Read data is taken once at the start of the strobe and then held
        if (!rd_n && !cs_n) begin
            next_st.oe_n = 1'b0;
            if (st.rd_q) begin
                next_st.dout = st.dout;
            end else if (hit_stack) begin
                next_st.dout = stk_data;
            end else if (st.addr == SARSTK_OFF_CTRL_A) begin
                next_st.dout = st.ctrl_a;
            end else begin
                next_st.dout = 8'h00;
            end
        end else begin
            next_st.oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{ale_q: 1'b0, rd_q: 1'b0, wr_q: 1'b0, addr: 7'h00,
                    ctrl_a: SARSTK_CTRL_A_RESET, dout: 8'h00, oe_n: 1'b1};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign bus_out = st.dout;
    assign bus_oe_n = st.oe_n;
    assign bank_select_bit = st.ctrl_a[SARSTK_BANK_BIT];
endmodule // sarstk_top
`default_nettype wire

// ---- verification/sarstk_host.sv ----
// Host model driving the multiplexed bus
`timescale 1ns/1ns
`default_nettype none
module sarstk_host (
    input wire logic clk,
    input wire logic [7:0] bus_out,
    output logic addr_latch, rd_n, wr_n, cs_n,
    output logic [7:0] bus_in
);
    initial {addr_latch, rd_n, wr_n, cs_n, bus_in} = 12'h75A;
    task automatic lat(logic [7:0] a);
        @(posedge clk) #1 {addr_latch, bus_in} = {1'b1, a};
        @(posedge clk) #1 addr_latch = 0;
        @(posedge clk) #1 bus_in = ~a;
        repeat (2) @(posedge clk);
    endtask
    task automatic acc(logic w, logic [7:0] d, output logic [7:0] q);
        @(posedge clk) #1 {cs_n, rd_n, wr_n, bus_in} = {1'b0, w, !w, d};
        @(posedge clk) #1 q = bus_out;
        @(posedge clk) #1 {cs_n, rd_n, wr_n, bus_in} = {3'h7, ~d};
    endtask
endmodule // sarstk_host
`default_nettype wire

// ---- verification/sarstk_monitor.sv ----
// Checker and bind for the recovery stack
`timescale 1ns/1ns
`default_nettype none
module sarstk_monitor (
    input wire logic clk, rst_n, addr_latch, rd_n, wr_n, cs_n, bus_oe_n, bank_select_bit,
    input wire logic [7:0] bus_in, bus_out
);
    logic [31:0] s;
    wire logic r = !rd_n && !cs_n;
    wire logic b = bank_select_bit;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Reference copy of the stack, newest entry in the low byte
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) s <= '0;
        else if ($fell(addr_latch)) s <= {s[23:0], b, bus_in[6:0]};
    slot_two_a: assert property (r && b && s[6:0] == 7'h4E |=> bus_out == s[23:16]) else $error("two");
    slot_three_a: assert property (r && b && s[6:0] == 7'h4F |=> bus_out == s[31:24]) else $error("three");
    read_zero_a: assert property (r && s[6:0] != 7'h0A && !(b && s[6:1] == 6'h27) |=> bus_out == 8'h00)
        else $error("zero");
    bank_write_a: assert property (!wr_n && !cs_n && s[6:0] == 7'h0A |=> b == $past(bus_in[4])) else $error("bank");
    bank_keep_a: assert property (!wr_n && !cs_n && s[6:0] != 7'h0A |=> $stable(b)) else $error("keep");
    oe_on_a: assert property (r |=> !bus_oe_n) else $error("oe on");
    oe_off_a: assert property (!r |=> bus_oe_n) else $error("oe off");
    data_hold_a: assert property (r [*2] |=> $stable(bus_out)) else $error("hold");
    cover property (r && b && s[6:0] == 7'h4E);
    cover property (!wr_n && !cs_n && s[6:0] == 7'h0A);
    cover property (r [*2]);
endmodule // sarstk_monitor
bind sarstk_top sarstk_monitor mon (.clk(clk), .rst_n(rst_n), .addr_latch(addr_latch), .rd_n(rd_n),
    .wr_n(wr_n), .cs_n(cs_n), .bus_oe_n(bus_oe_n), .bank_select_bit(bank_select_bit),
    .bus_in(bus_in), .bus_out(bus_out));
`default_nettype wire

// ---- verification/sarstk_tb.sv ----
// Bench for the recovery stack
`timescale 1ns/1ns
`default_nettype none
module sarstk_tb;
    logic clk = 0, rst_n = 0, al, rn, wn, cn, oe, bk;
    logic [7:0] bi, bo, q;
    int n_fail = 0, checks = 0, t = 0;
    always #4 clk = ~clk;
    sarstk_top dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .addr_latch(al), .rd_n(rn),
        .wr_n(wn), .cs_n(cn), .bus_in(bi), .bus_out(bo), .bus_oe_n(oe), .bank_select_bit(bk));
    sarstk_host h (.clk(clk), .bus_out(bo), .addr_latch(al), .rd_n(rn), .wr_n(wn), .cs_n(cn),
        .bus_in(bi));
    task automatic chk(string n, logic [7:0] e);
        checks++;
        if (q !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", n, e, q);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rd(logic [7:0] a);
        h.lat(a);
        h.acc(0, 8'h00, q);
    endtask
    task automatic bank(logic [7:0] v);
        h.lat(8'h0A);
        h.acc(1, v, q);
    endtask
    task automatic t_recover;
        bank(8'h10);
        chk1("bank_on", 1'b1, bk);
        h.lat(8'h23);
        bank(8'h10);
        rd(8'h4E);
        chk("slot4E", 8'hA3);
        rd(8'h4F);
        chk("slot4F", 8'hA3);
    endtask
    task automatic t_refuse;
        rd(8'h4E);
        chk1("oe_low", 1'b0, oe);
        @(posedge clk) #1 chk1("oe_high", 1'b1, oe);
        h.acc(1, 8'hFF, q);
        h.acc(0, 8'h00, q);
        chk("readonly", 8'hCE);
        rd(8'h0A);
        chk("ctrl_a", 8'h10);
        rd(8'h33);
        chk("other", 8'h00);
        bank(8'h00);
        chk1("bank_off", 1'b0, bk);
        rd(8'h4E);
        chk("nobank", 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        t_recover();
        t_refuse();
        end_sim();
    end
    always @(posedge clk) begin
        t++;
        if (t == 400) begin
            n_fail++;
            end_sim();
        end
    end
endmodule // sarstk_tb
`default_nettype wire
